// ===== rtl/charger_status_adc_readback.v
// charger status and measurement readback register group
//
// Function
// - phase field bits 7:5 reports charge phase
// - bit 4 set when safety timer expired
// - register reset command clears timer, thermal flags
// - bit 3 set during thermal regulation
// - bits 2:0 report strapped mode pin
// - status at 19h, read-only, resets 00h
// - battery voltage low 1Ah, high 1Bh
// - battery voltage 1 mV, negative clamps zero
// - system power low 1Ch, high 1Dh
// - system power clamps 1FFFh, command clears
// - charger-ok pulled low 256 us on change
`timescale 1ns/1ps
`default_nettype none
`include "charger_status_consts.vh"

module charger_status_adc_readback #(
	parameter [15:0] OK_PULSE_CYCLES = `OK_PULSE_CYCLES
) (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// software register reset command, one cycle
	input  wire        reg_reset,
	// charger state inputs
	input  wire [2:0]  charge_phase_in,
	input  wire        safety_timer_expired,
	input  wire        thermal_limit_state,
	input  wire [2:0]  mode_strap,
	input  wire        status_change_interrupt_enable,
	// converter results
	input  wire        vbat_valid,
	input  wire [15:0] vbat_raw,
	input  wire        psys_valid,
	input  wire [15:0] psys_raw,
	// register read port from the serial engine
	input  wire        rd_en,
	input  wire [7:0]  rd_addr,
	output reg         rd_valid_ff,
	output reg  [7:0]  rd_data_ff,
	// open-drain charger-ok pin
	output reg         charger_ok_output_out_ff,
	output reg         charger_ok_output_oe_ff
);

	reg  [2:0]  charge_phase_field_ff;
	reg  [2:0]  nxt_phase;
	reg         safety_timer_expired_flag_ff;
	reg         thermal_regulation_flag_ff;
	reg         timer_prev_ff;
	reg         thermal_prev_ff;
	reg  [2:0]  mode_ff;
	reg         strap_taken_ff;
	reg  [15:0] ok_count_ff;
	reg  [7:0]  nxt_rd_data;
	wire [7:0]  status_byte;
	wire        timer_rise;
	wire        thermal_rise;
	wire        phase_change;
	wire        vbat_low_read;
	wire        psys_low_read;
	wire [15:0] vbat_value;
	wire [7:0]  vbat_high_snap;
	wire [15:0] psys_value;
	wire [7:0]  psys_high_snap;

	// reserved phase codes keep the last reported phase
	always @* begin
		case (charge_phase_in)
			`PHASE_IDLE,
			`PHASE_TRICKLE,
			`PHASE_PRECHARGE,
			`PHASE_FAST_CC,
			`PHASE_FAST_CV,
			`PHASE_DONE: begin
				nxt_phase = charge_phase_in;
			end
			default: begin
				nxt_phase = charge_phase_field_ff;
			end
		endcase
	end

	assign phase_change = (nxt_phase != charge_phase_field_ff);

	always @(posedge clock) begin
		if (rst)
			charge_phase_field_ff <= `PHASE_IDLE;
		else
			charge_phase_field_ff <= nxt_phase;
	end

	// flags follow their level; the command clears until a new rise,
	// and a rise in the clearing cycle still sets the flag
	assign timer_rise   = safety_timer_expired & ~timer_prev_ff;
	assign thermal_rise = thermal_limit_state & ~thermal_prev_ff;

	always @(posedge clock) begin
		if (rst) begin
			timer_prev_ff                <= 1'b0;
			thermal_prev_ff              <= 1'b0;
			safety_timer_expired_flag_ff <= 1'b0;
			thermal_regulation_flag_ff   <= 1'b0;
		end else begin
			timer_prev_ff   <= safety_timer_expired;
			thermal_prev_ff <= thermal_limit_state;
			if (timer_rise)
				safety_timer_expired_flag_ff <= 1'b1;
			else if (reg_reset || !safety_timer_expired)
				safety_timer_expired_flag_ff <= 1'b0;
			if (thermal_rise)
				thermal_regulation_flag_ff <= 1'b1;
			else if (reg_reset || !thermal_limit_state)
				thermal_regulation_flag_ff <= 1'b0;
		end
	end

	// strap taken once, in the first cycle after reset release
	always @(posedge clock) begin
		if (rst) begin
			mode_ff        <= 3'h0;
			strap_taken_ff <= 1'b0;
		end else if (!strap_taken_ff) begin
			mode_ff        <= mode_strap;
			strap_taken_ff <= 1'b1;
		end
	end

	assign status_byte = {charge_phase_field_ff,
	                      safety_timer_expired_flag_ff,
	                      thermal_regulation_flag_ff,
	                      mode_ff};

	// measurement results
	assign vbat_low_read = rd_en && (rd_addr == `ADDR_BATTERY_VOLTAGE_LO);
	assign psys_low_read = rd_en && (rd_addr == `ADDR_SYSTEM_POWER_LO);

	adc_result_hold #(
		.RAW_SIGNED   (1),
		.MAX_CODE     (`BATTERY_VOLTAGE_MAX),
		.CLEAR_ON_CMD (0)
	) u_vbat (
		.clock        (clock),
		.rst          (rst),
		.reg_reset    (reg_reset),
		.sample_valid (vbat_valid),
		.sample_raw   (vbat_raw),
		.low_read     (vbat_low_read),
		.value_ff     (vbat_value),
		.high_snap_ff (vbat_high_snap)
	);

	adc_result_hold #(
		.RAW_SIGNED   (0),
		.MAX_CODE     (`SYSTEM_POWER_MAX),
		.CLEAR_ON_CMD (1)
	) u_psys (
		.clock        (clock),
		.rst          (rst),
		.reg_reset    (reg_reset),
		.sample_valid (psys_valid),
		.sample_raw   (psys_raw),
		.low_read     (psys_low_read),
		.value_ff     (psys_value),
		.high_snap_ff (psys_high_snap)
	);

	// read decode; unmapped addresses read zero
	always @* begin
		case (rd_addr)
			`ADDR_CHARGE_CYCLE_STATUS: nxt_rd_data = status_byte;
			`ADDR_BATTERY_VOLTAGE_LO:  nxt_rd_data = vbat_value[7:0];
			`ADDR_BATTERY_VOLTAGE_HI:  nxt_rd_data = vbat_high_snap;
			`ADDR_SYSTEM_POWER_LO:     nxt_rd_data = psys_value[7:0];
			`ADDR_SYSTEM_POWER_HI:     nxt_rd_data = psys_high_snap;
			default:                   nxt_rd_data = `RST_READ_DATA;
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			rd_valid_ff <= 1'b0;
			rd_data_ff  <= `RST_READ_DATA;
		end else begin
			rd_valid_ff <= rd_en;
			if (rd_en)
				rd_data_ff <= nxt_rd_data;
		end
	end

	// charger-ok low pulse, restarted by every phase change while status_change_interrupt_enable is set
	always @(posedge clock) begin
		if (rst) begin
			ok_count_ff              <= 16'h0000;
			charger_ok_output_out_ff <= 1'b0;
			charger_ok_output_oe_ff  <= 1'b0;
		end else begin
			charger_ok_output_out_ff <= 1'b0;
			if (phase_change && status_change_interrupt_enable) begin
				ok_count_ff             <= OK_PULSE_CYCLES - 16'h0001;
				charger_ok_output_oe_ff <= 1'b1;
			end else if (ok_count_ff != 16'h0000) begin
				ok_count_ff             <= ok_count_ff - 16'h0001;
				charger_ok_output_oe_ff <= 1'b1;
			end else begin
				charger_ok_output_oe_ff <= 1'b0;
			end
		end
	end

endmodule // charger_status_adc_readback

`default_nettype wire

// ===== rtl/charger_status_consts.vh
// constants for the charger status and measurement readback registers
`ifndef CHARGER_STATUS_CONSTS_VH
`define CHARGER_STATUS_CONSTS_VH

// byte addresses of the register group
`define ADDR_CHARGE_CYCLE_STATUS   8'h19
`define ADDR_BATTERY_VOLTAGE_LO    8'h1A
`define ADDR_BATTERY_VOLTAGE_HI    8'h1B
`define ADDR_SYSTEM_POWER_LO       8'h1C
`define ADDR_SYSTEM_POWER_HI       8'h1D

// charge_cycle_status field positions
`define PHASE_MSB                  7
`define PHASE_LSB                  5
`define TIMER_BIT                  4
`define THERMAL_BIT                3
`define MODE_MSB                   2
`define MODE_LSB                   0

// charge phase codes
`define PHASE_IDLE                 3'h0
`define PHASE_TRICKLE              3'h1
`define PHASE_PRECHARGE            3'h2
`define PHASE_FAST_CC              3'h3
`define PHASE_FAST_CV              3'h4
`define PHASE_RSVD_A               3'h5
`define PHASE_RSVD_B               3'h6
`define PHASE_DONE                 3'h7

// reset values
`define RST_STATUS                 8'h00
`define RST_RESULT                 16'h0000
`define RST_READ_DATA              8'h00

// result clamp limits
`define BATTERY_VOLTAGE_MAX        16'h7FFF
`define SYSTEM_POWER_MAX           16'h1FFF

// charger-ok low pulse on a phase change
// 256 us at the 100 MHz clock, sized to the pulse counter
`define OK_PULSE_CYCLES            16'h6400

`endif

// ===== rtl/adc_result_hold.v
// one clamped 16-bit measurement result with a coherent high-byte snapshot
`timescale 1ns/1ps
`default_nettype none
`include "charger_status_consts.vh"

module adc_result_hold #(
	parameter        RAW_SIGNED   = 1,
	parameter [15:0] MAX_CODE     = 16'h7FFF,
	parameter        CLEAR_ON_CMD = 0
) (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// software register reset command
	input  wire        reg_reset,
	// new converter sample
	input  wire        sample_valid,
	input  wire [15:0] sample_raw,
	// low byte is being read this cycle
	input  wire        low_read,
	// held result and high byte frozen at the last low read
	output reg  [15:0] value_ff,
	output reg  [7:0]  high_snap_ff
);

	reg  [15:0] nxt_value;
	wire        is_negative;
	wire        over_max;

	assign is_negative = (RAW_SIGNED != 0) && sample_raw[15];
	assign over_max    = (sample_raw > MAX_CODE);

	// clamp below zero and above the top code
	always @* begin
		nxt_value = value_ff;
		if (sample_valid) begin
			if (is_negative)
				nxt_value = `RST_RESULT;
			else if (over_max)
				nxt_value = MAX_CODE;
			else
				nxt_value = sample_raw;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			value_ff     <= `RST_RESULT;
			high_snap_ff <= `RST_READ_DATA;
		end else begin
			if (reg_reset && (CLEAR_ON_CMD != 0))
				value_ff <= `RST_RESULT;
			else
				value_ff <= nxt_value;
			// freeze the upper byte that pairs with the low byte read
			if (low_read)
				high_snap_ff <= value_ff[15:8];
		end
	end

endmodule // adc_result_hold

`default_nettype wire

// ===== dv/charger_status_monitor.sv
// checker on the charger status readback ports
`timescale 1ns/1ps
`default_nettype none
module charger_status_monitor #(
	parameter logic [15:0] OK_PULSE_CYCLES = 16'h0008
) (
	// clock and reset
	input wire logic	clock,
	input wire logic	rst,
	// inputs
	input wire logic	reg_reset,
	input wire logic	safety_timer_expired,
	input wire logic	thermal_limit_state,
	input wire logic	vbat_valid,
	input wire logic [15:0]	vbat_raw,
	input wire logic	psys_valid,
	input wire logic [15:0]	psys_raw,
	input wire logic	rd_en,
	input wire logic [7:0]	rd_addr,
	// outputs
	input wire logic	rd_valid_ff,
	input wire logic [7:0]	rd_data_ff,
	input wire logic	charger_ok_output_out_ff,
	input wire logic	charger_ok_output_oe_ff
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic	st_rd = rd_en && rd_addr == 8'h19;
	logic [15:0]	hi_cnt_ff;
	// cycles the pin has been pulled low so far
	always_ff @(posedge clock)
		hi_cnt_ff <= (rst || !charger_ok_output_oe_ff) ? 16'h0000
			: hi_cnt_ff + 16'h0001;
	property p_rd_answer; rd_en |=> rd_valid_ff; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	property p_no_rsvd;
		st_rd |=> rd_data_ff[7:5] != 3'h5 && rd_data_ff[7:5] != 3'h6;
	endproperty
	a_no_rsvd: assert property (p_no_rsvd)
		else $error("reserved phase code");
	property p_pin_low; !charger_ok_output_out_ff; endproperty
	a_pin_low: assert property (p_pin_low)
		else $error("pin driven high");
	property p_pulse_len;
		$fell(charger_ok_output_oe_ff) |-> hi_cnt_ff >= OK_PULSE_CYCLES;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("pulse too short");
	property p_psys_clamp;
		psys_valid && psys_raw > 16'h1FFF && !reg_reset
		##1 !psys_valid && !reg_reset
		##1 rd_en && rd_addr == 8'h1C && !psys_valid && !reg_reset
		|=> rd_data_ff == 8'hFF;
	endproperty
	a_psys_clamp: assert property (p_psys_clamp)
		else $error("power not clamped");
	property p_vbat_neg;
		vbat_valid && vbat_raw[15] ##1 !vbat_valid
		##1 rd_en && rd_addr == 8'h1A && !vbat_valid |=> rd_data_ff == 8'h00;
	endproperty
	a_vbat_neg: assert property (p_vbat_neg)
		else $error("negative voltage not zero");
	property p_thermal_set;
		$rose(thermal_limit_state) ##1 thermal_limit_state && !reg_reset
		&& st_rd |=> rd_data_ff[3];
	endproperty
	a_thermal_set: assert property (p_thermal_set)
		else $error("thermal flag not set");
	property p_flag_clear;
		reg_reset && !$rose(safety_timer_expired) && !$rose(thermal_limit_state)
		##1 !$rose(safety_timer_expired) && !$rose(thermal_limit_state)
		##1 st_rd |=> rd_data_ff[4:3] == 2'b00;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flags not cleared");
	c_pulse: cover property ($rose(charger_ok_output_oe_ff));
	c_clamp: cover property (psys_valid && psys_raw > 16'h1FFF);
	c_clear: cover property (reg_reset ##2 st_rd);
endmodule // charger_status_monitor
bind charger_status_adc_readback charger_status_monitor #(
	.OK_PULSE_CYCLES(OK_PULSE_CYCLES)) mon (.clock(clock), .rst(rst),
	.reg_reset(reg_reset), .safety_timer_expired(safety_timer_expired),
	.thermal_limit_state(thermal_limit_state), .vbat_valid(vbat_valid),
	.vbat_raw(vbat_raw), .psys_valid(psys_valid), .psys_raw(psys_raw),
	.rd_en(rd_en), .rd_addr(rd_addr), .rd_valid_ff(rd_valid_ff),
	.rd_data_ff(rd_data_ff),
	.charger_ok_output_out_ff(charger_ok_output_out_ff),
	.charger_ok_output_oe_ff(charger_ok_output_oe_ff));
`default_nettype wire

// ===== dv/serial_host_model.sv
// byte reader standing in for the serial host engine
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	// clock
	input wire logic	clock,
	// read port
	output logic	rd_en,
	output logic [7:0]	rd_addr,
	input wire logic	rd_valid_ff,
	input wire logic [7:0]	rd_data_ff
);
	initial begin
		rd_en = 1'b0;
		rd_addr = 8'h00;
	end
	// address is inverted once taken so a stale value is never seen
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clock);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		rd_addr <= ~a;
		#1;
		v = rd_valid_ff;
		d = rd_data_ff;
	endtask
endmodule // serial_host_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the charger status readback block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic	clock, rst, reg_reset, timer, thermal, irq_en, v;
	logic	vbat_valid, psys_valid, rd_en, rd_valid_ff, ok_out, ok_oe;
	logic [2:0]	phase, strap;
	logic [15:0]	vbat_raw, psys_raw;
	logic [7:0]	rd_addr, rd_data_ff, d;
	int	mismatches, checks_done, cyc;
	charger_status_adc_readback #(.OK_PULSE_CYCLES(16'h0008)) dut (
		.clock(clock), .rst(rst), .reg_reset(reg_reset),
		.charge_phase_in(phase), .safety_timer_expired(timer),
		.thermal_limit_state(thermal), .mode_strap(strap),
		.status_change_interrupt_enable(irq_en), .vbat_valid(vbat_valid),
		.vbat_raw(vbat_raw), .psys_valid(psys_valid), .psys_raw(psys_raw),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_valid_ff(rd_valid_ff),
		.rd_data_ff(rd_data_ff), .charger_ok_output_out_ff(ok_out),
		.charger_ok_output_oe_ff(ok_oe));
	serial_host_model host (.clock(clock), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rc(input logic [7:0] a, exp);
		host.rd(a, d, v);
		chk("read valid", 8'h01, {7'h00, v});
		chk($sformatf("byte %h", a), exp, d);
	endtask
	task automatic sample(input logic sys, input logic [15:0] x);
		@(posedge clock);
		vbat_valid <= !sys;
		psys_valid <= sys;
		vbat_raw <= x;
		psys_raw <= x;
		@(posedge clock);
		vbat_valid <= 1'b0;
		psys_valid <= 1'b0;
	endtask
	task automatic cmd_reset();
		@(posedge clock);
		reg_reset <= 1'b1;
		@(posedge clock);
		reg_reset <= 1'b0;
	endtask
	task automatic count_low(output int n);
		n = 0;
		repeat (20) begin
			@(posedge clock);
			#1;
			if (ok_oe === 1'b1)
				n++;
		end
	endtask
	task automatic t_results();
		rc(8'h19, 8'h05);
		for (int i = 0; i < 4; i++)
			rc(8'h1A + 8'(i), 8'h00);
		rc(8'h20, 8'h00);
		sample(1'b0, 16'h1234);
		rc(8'h1A, 8'h34);
		sample(1'b0, 16'h5678);
		rc(8'h1B, 8'h12);
		sample(1'b0, 16'h8001);
		rc(8'h1A, 8'h00);
		rc(8'h1B, 8'h00);
		sample(1'b0, 16'h7FFF);
		sample(1'b1, 16'hFFFF);
		rc(8'h1C, 8'hFF);
		rc(8'h1D, 8'h1F);
		sample(1'b1, 16'h1ABC);
		rc(8'h1C, 8'hBC);
		rc(8'h1D, 8'h1A);
		cmd_reset();
		rc(8'h1C, 8'h00);
		rc(8'h1A, 8'hFF);
		rc(8'h1B, 8'h7F);
	endtask
	task automatic t_flags();
		@(posedge clock);
		timer <= 1'b1;
		thermal <= 1'b1;
		rc(8'h19, 8'h1D);
		cmd_reset();
		rc(8'h19, 8'h05);
		@(posedge clock);
		timer <= 1'b0;
		thermal <= 1'b0;
		@(posedge clock);
		timer <= 1'b1;
		rc(8'h19, 8'h15);
		@(posedge clock);
		timer <= 1'b0;
		rc(8'h19, 8'h05);
	endtask
	task automatic t_phase();
		logic [2:0] last;
		int n;
		last = 3'h0;
		for (int c = 1; c < 9; c++) begin
			@(posedge clock);
			phase <= 3'(c);
			if (c != 5 && c != 6)
				last = 3'(c);
			rc(8'h19, {last, 5'h05});
		end
		@(posedge clock);
		irq_en <= 1'b1;
		phase <= 3'h3;
		count_low(n);
		chk("pulse cycles", 8'h08, 8'(n));
		chk("pin level", 8'h00, {7'h00, ok_out});
		@(posedge clock);
		irq_en <= 1'b0;
		phase <= 3'h1;
		count_low(n);
		chk("pulse cycles", 8'h00, 8'(n));
	endtask
	// mid-run reset with a new strap: battery voltage result cleared, strap retaken
	task automatic t_strap();
		@(posedge clock);
		rst <= 1'b1;
		strap <= 3'h2;
		phase <= 3'h0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rc(8'h19, 8'h02);
		rc(8'h1A, 8'h00);
		rc(8'h1B, 8'h00);
	endtask
	initial begin
		rst = 1'b1;
		{reg_reset, timer, thermal, irq_en, vbat_valid, psys_valid} = 6'h00;
		phase = 3'h0;
		strap = 3'h5;
		vbat_raw = 16'h0000;
		psys_raw = 16'h0000;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_results();
		t_flags();
		t_phase();
		t_strap();
		give_verdict();
	end
endmodule // tb
`default_nettype wire
